// *** bench/fbc_flash_model.sv ***
// Behavioural model of the parallel flash part facing the host.
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model #(
    parameter logic [7:0] MAKER = 8'hc3, // Arbitrary value.
    parameter logic [7:0] PART  = 8'h4e, // Arbitrary value.
    parameter logic [7:0] CONT  = 8'h5b, // Arbitrary value.
    parameter int         T_ACC = 70,    // Read access time in ns.
    parameter int         T_OP  = 600    // Embedded operation time in ns.
) (
    // Flash pins.
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [18:0] i_a,
    input  wire logic [7:0]  i_dq,
    output logic      [7:0]  o_dq,
    // Protection flags, set only by programming equipment.
    input  wire logic [7:0]  i_prot
);
    // Sixteen bytes a sector are kept, so higher low bits alias.
    logic [7:0]  mem [0:127];
    logic [18:0] la;            // Latched write address.
    logic [7:0]  pd, last, rd;  // Target, last driven and read bytes.
    logic [2:0]  st;            // Command state; seven is identification.
    logic        busy, tog, wr_on, ok;
    time         t_chg, t_lat;
    function automatic int ix(input logic [18:0] a);
        return {a[18:16], a[3:0]};
    endfunction : ix
    // Starts an embedded operation that ends on its own.
    task automatic run(input logic [7:0] v);
        busy = 1'b1;
        pd = v;
        busy <= #(T_OP) 1'b0;
    endtask : run
    // Decodes one accepted write against the command sequence.
    task automatic cmd(input logic [18:0] a, input logic [7:0] d);
        logic u1, u2, p;
        u1 = (a[10:0] == 11'h555) && (d == 8'haa);
        u2 = (a[10:0] == 11'h2aa) && (d == 8'h55);
        p = i_prot[a[18:16]];
        if (busy) return;
        case (st)
            3'd0: st = u1 ? 3'd1 : 3'd0;
            3'd1: st = u2 ? 3'd2 : 3'd0;
            3'd2: st = (d == 8'ha0) ? 3'd3 : (d == 8'h80) ? 3'd4 :
                       (d == 8'h90) ? 3'd7 : 3'd0;
            3'd3: begin
                st = 3'd0;
                if (!p) begin
                    mem[ix(a)] = mem[ix(a)] & d;
                    run(mem[ix(a)]);
                end
            end
            3'd4: st = u1 ? 3'd5 : 3'd0;
            3'd5: st = u2 ? 3'd6 : 3'd0;
            3'd6: begin
                st = 3'd0;
                for (int i = 0; i < 128; i++) begin
                    if (!i_prot[i[6:4]] && (d == 8'h10 ||
                        (d == 8'h30 && i[6:4] == a[18:16]))) mem[i] = 8'hff;
                end
                if (d == 8'h10 || (d == 8'h30 && !p)) run(8'hff);
            end
            default: st = 3'd7; // Identification holds until reset.
        endcase
        if (d == 8'hf0) st = 3'd0;
    endtask : cmd
    // Array pattern at power-up; no flag set, all sectors open.
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'h5a ^ i[7:0];
        {st, busy, tog, wr_on, ok, last, pd, t_chg, t_lat} = '0;
    end
    // The address is taken when the later strobe falls.
    always @(negedge i_ce_n or negedge i_we_n) begin
        if (!i_ce_n && !i_we_n && i_oe_n) begin
            la = i_a;
            t_lat = $time;
            wr_on = 1'b1; // Strobes low at power-up never arm this.
        end
    end
    // Data is taken when the earlier strobe rises; glitches are dropped.
    always @(posedge i_ce_n or posedge i_we_n) begin
        if (wr_on) begin
            wr_on = 1'b0;
            if ($time - t_lat >= 5) cmd(la, i_dq);
        end
    end
    // Any change of address or read strobes restarts the access time.
    always @(i_a or i_ce_n or i_oe_n) t_chg = $time;
    always #1 ok = ($time - t_chg) >= T_ACC;
    // Each status read flips the toggle bit.
    always @(negedge i_oe_n) if (busy) tog = ~tog;
    always @* begin
        if (busy) rd = {~pd[7], tog, 6'h00};
        else if (st == 3'd7) begin
            case (i_a[1:0])
                2'd0: rd = MAKER;
                2'd1: rd = PART;
                2'd2: rd = {7'h00, i_prot[i_a[18:16]]};
                default: rd = CONT;
            endcase
        end else rd = mem[ix(i_a)];
    end
    // Released lines show the inverse of the last byte driven.
    always @* begin
        if (!i_ce_n && !i_oe_n && i_we_n && ok) begin
            o_dq = rd;
            last = rd;
        end else o_dq = ~last;
    end
endmodule : fbc_flash_model
`default_nettype wire

// *** bench/fbc_host_chk.sv ***
// Pin protocol checker for the flash bus host controller.
`timescale 1ns/1ps
`default_nettype none
module fbc_host_chk (
    // Clock and reset.
    input wire logic                       I_CLK_SYS,
    input wire logic                       I_SRST,
    // Request side.
    input wire logic                       I_REQ,
    input wire logic                       O_BUSY,
    input wire logic                       O_DONE,
    // Flash pins.
    input wire logic                       O_CE_N,
    input wire logic                       O_OE_N,
    input wire logic                       O_WE_N,
    input wire logic [fbc_pkg::ADDR_W-1:0] O_A,
    input wire logic [fbc_pkg::DATA_W-1:0] O_DQ,
    input wire logic                       O_DQ_OE_N
);
    // All checks share the system clock and its reset.
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_SRST);
    // A write strobe stays low four cycles, then is released.
    sequence s_we_low;
        !O_WE_N [*4] ##1 O_WE_N;
    endsequence
    // Select must already be low three cycles before the strobe falls.
    sequence s_setup;
        $past(O_CE_N, 3) == 1'b0;
    endsequence
    AST_READ_LEVELS: assert property (!O_OE_N |-> !O_CE_N && O_WE_N)
        else $error("read gate low without select or with strobe low");
    AST_WRITE_LEVELS: assert property (!O_WE_N |-> !O_CE_N && O_OE_N)
        else $error("write strobe low without select or with gate low");
    AST_NO_FIGHT: assert property (!O_DQ_OE_N |-> O_OE_N)
        else $error("host drives data while flash outputs are gated on");
    AST_WE_PULSE: assert property ($fell(O_WE_N) |-> s_we_low)
        else $error("write strobe width is not four cycles");
    AST_WE_SETUP: assert property ($fell(O_WE_N) |-> s_setup)
        else $error("write strobe fell too soon after select");
    AST_ADDR_HOLD: assert property (!O_CE_N && !$past(O_CE_N) |-> $stable(O_A))
        else $error("address moved while selected");
    AST_DATA_HOLD: assert property (!O_WE_N |=> $stable(O_DQ))
        else $error("write data moved before strobe release");
    AST_DONE_PULSE: assert property (O_DONE |=> !O_DONE)
        else $error("done lasted more than one cycle");
    AST_ACCEPT: assert property (I_REQ && !O_BUSY && !O_DONE |=> O_BUSY)
        else $error("idle request was not accepted");
endmodule : fbc_host_chk
bind fbc_host fbc_host_chk fbc_host_chk_inst (
    .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .I_REQ(I_REQ),
    .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_CE_N(O_CE_N), .O_OE_N(O_OE_N),
    .O_WE_N(O_WE_N), .O_A(O_A), .O_DQ(O_DQ), .O_DQ_OE_N(O_DQ_OE_N)
);
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the flash bus host controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] MAKER = 8'hc3; // Arbitrary value.
    localparam logic [7:0] PART  = 8'h4e; // Arbitrary value.
    localparam logic [7:0] CONT  = 8'h5b; // Arbitrary value.
    logic             I_CLK_SYS, I_SRST, I_REQ, O_BUSY, O_DONE;
    logic             O_CE_N, O_OE_N, O_WE_N, O_DQ_OE_N;
    fbc_pkg::fbc_op_t I_OP;
    logic [18:0]      I_ADDR, O_A;
    logic [7:0]       I_WDATA, O_RDATA, O_DQ, I_DQ, host_dq, prot, r;
    int               err_count, samples_checked;
    // A released host bus shows the flash the inverse of its last byte.
    assign host_dq = O_DQ_OE_N ? ~O_DQ : O_DQ;
    fbc_host fbc_host_inst (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST),
        .I_REQ(I_REQ), .I_OP(I_OP), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_RDATA(O_RDATA),
        .O_CE_N(O_CE_N), .O_OE_N(O_OE_N), .O_WE_N(O_WE_N), .O_A(O_A),
        .O_DQ(O_DQ), .O_DQ_OE_N(O_DQ_OE_N), .I_DQ(I_DQ));
    fbc_flash_model #(.MAKER(MAKER), .PART(PART), .CONT(CONT))
        fbc_flash_model_inst (.i_ce_n(O_CE_N), .i_oe_n(O_OE_N),
        .i_we_n(O_WE_N), .i_a(O_A), .i_dq(host_dq), .o_dq(I_DQ),
        .i_prot(prot));
    initial begin
        I_CLK_SYS = 1'b0;
        forever #5 I_CLK_SYS = ~I_CLK_SYS;
    end
    function automatic logic [7:0] pat(input logic [18:0] a);
        return 8'h5a ^ {1'b0, a[18:16], a[3:0]};
    endfunction : pat
    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk
    // Issues one operation and waits a bounded time for its done pulse.
    task automatic op(input fbc_pkg::fbc_op_t o, input logic [18:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge I_CLK_SYS);
        I_REQ <= 1'b1;
        I_OP <= o;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK_SYS);
        I_REQ <= 1'b0;
        n = 0;
        do begin
            @(posedge I_CLK_SYS);
            #1;
            n++;
        end while (O_DONE !== 1'b1 && n < 300);
        if (O_DONE !== 1'b1) chk("done", 8'h01, 8'h00);
        q = O_RDATA;
    endtask : op
    task automatic rd(input logic [18:0] a, input logic [7:0] e);
        op(fbc_pkg::OP_READ, a, 8'h00, r);
        chk("read data", e, r);
    endtask : rd
    // First read must be status; then poll until the target byte shows.
    task automatic poll(input logic [18:0] a, input logic [7:0] e);
        op(fbc_pkg::OP_READ, a, 8'h00, r);
        chk("status bit", {7'h00, ~e[7]}, {7'h00, r[7]});
        for (int n = 0; n < 20 && r !== e; n++)
            op(fbc_pkg::OP_READ, a, 8'h00, r);
        chk("ready data", e, r);
    endtask : poll
    task automatic t_boot();
        for (int s = 0; s < 8; s++) // Every sector reads at once.
            rd({s[2:0], 16'hfff7}, pat({s[2:0], 16'hfff7}));
    endtask : t_boot
    task automatic t_id();
        logic [7:0] ids [4];
        ids = '{MAKER, PART, 8'h00, CONT};
        for (int k = 0; k < 4; k++) begin
            op(fbc_pkg::OP_ID_READ, {17'h08000, k[1:0]}, 8'h00, r);
            chk("id code", ids[k], r);
        end
        prot <= 8'h04; // Equipment protects sector two.
        op(fbc_pkg::OP_ID_READ, 19'h2_0002, 8'h00, r);
        chk("protect flag", 8'h01, r);
        rd(19'h0_0001, PART); // Mode persists across reads.
        op(fbc_pkg::OP_RESET, 19'h0_0000, 8'h00, r);
        rd(19'h0_0001, pat(19'h0_0001));
    endtask : t_id
    task automatic t_prot();
        op(fbc_pkg::OP_PROG, 19'h2_0005, 8'h00, r);
        rd(19'h2_0005, pat(19'h2_0005));
        op(fbc_pkg::OP_SECT_ERASE, 19'h2_0000, 8'h00, r);
        rd(19'h2_0005, pat(19'h2_0005));
        prot <= 8'h00;
        op(fbc_pkg::OP_PROG, 19'h2_0005, 8'h00, r);
        poll(19'h2_0005, 8'h00);
    endtask : t_prot
    task automatic t_prog();
        op(fbc_pkg::OP_PROG, 19'h5_0012, 8'h0f, r);
        op(fbc_pkg::OP_RESET, 19'h0_0000, 8'h00, r);
        poll(19'h5_0012, pat(19'h5_0012) & 8'h0f);
    endtask : t_prog
    // A broken unlock must leave the array untouched.
    task automatic t_bad();
        op(fbc_pkg::OP_WRITE, 19'h0_0555, 8'haa, r);
        op(fbc_pkg::OP_WRITE, 19'h0_02aa, 8'h77, r);
        op(fbc_pkg::OP_WRITE, 19'h0_0555, 8'ha0, r);
        op(fbc_pkg::OP_WRITE, 19'h3_0009, 8'h00, r);
        rd(19'h3_0009, pat(19'h3_0009));
    endtask : t_bad
    task automatic t_erase();
        op(fbc_pkg::OP_SECT_ERASE, 19'h6_0000, 8'h00, r);
        poll(19'h6_0001, 8'hff);
        op(fbc_pkg::OP_SECT_ERASE, 19'h7_0000, 8'h00, r);
        poll(19'h7_000e, 8'hff);
        rd(19'h5_0003, pat(19'h5_0003));
        op(fbc_pkg::OP_CHIP_ERASE, 19'h0_0000, 8'h00, r);
        poll(19'h5_0012, 8'hff);
        rd(19'h2_0005, 8'hff);
    endtask : t_erase
    task automatic conclude();
        if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    // Main sequence: hold reset six cycles, then run every scenario.
    initial begin
        {I_SRST, I_REQ, I_ADDR, I_WDATA, prot} = {1'b1, 36'h0};
        I_OP = fbc_pkg::OP_READ;
        err_count = 0;
        samples_checked = 0;
        repeat (6) @(posedge I_CLK_SYS);
        I_SRST <= 1'b0;
        t_boot();
        t_id();
        t_prot();
        t_prog();
        t_bad();
        t_erase();
        conclude();
    end
    // Watchdog: the whole run needs well under twenty thousand cycles.
    initial begin
        #200000;
        err_count++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire

// *** rtl/fbc_cycle.sv ***
// Single bus cycle engine driving the flash strobes and data lines.
`timescale 1ns/1ps
`default_nettype none
module fbc_cycle (
    // Clock and reset.
    input  wire logic                      i_clk,
    input  wire logic                      i_srst,
    // Cycle request.
    input  wire logic                      i_go,
    input  wire logic                      i_wr,
    input  wire logic [fbc_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [fbc_pkg::DATA_W-1:0] i_data,
    output logic                           o_done,
    output logic [fbc_pkg::DATA_W-1:0]     o_rdata,
    // Flash pins.
    output logic                           o_ce_n,
    output logic                           o_oe_n,
    output logic                           o_we_n,
    output logic [fbc_pkg::ADDR_W-1:0]     o_addr,
    output logic [fbc_pkg::DATA_W-1:0]     o_dq,
    output logic                           o_dq_oe_n,
    input  wire logic [fbc_pkg::DATA_W-1:0] i_dq_sync
);
    typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fbc_cy_t;
    fbc_cy_t                       st, next_st;
    logic [fbc_pkg::CNT_W-1:0]     cnt, next_cnt;
    logic                          wr, next_wr;
    logic [fbc_pkg::DATA_W-1:0]    next_rdata;
    logic                          next_done, next_ce_n, next_oe_n, next_we_n;
    logic [fbc_pkg::ADDR_W-1:0]    next_addr;
    logic [fbc_pkg::DATA_W-1:0]    next_dq;
    logic                          next_dq_oe_n;

    // Sequencer: setup, strobe, hold; all pins change on phase edges only.
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_wr = wr;
        next_rdata = o_rdata;
        next_done = 1'b0;
        next_ce_n = o_ce_n;
        next_oe_n = o_oe_n;
        next_we_n = o_we_n;
        next_addr = o_addr;
        next_dq = o_dq;
        next_dq_oe_n = o_dq_oe_n;
        unique case (st)
            CY_IDLE: begin
                // Idle keeps chip deselected so the part sits in standby.
                if (i_go) begin
                    next_st = CY_SETUP;
                    next_wr = i_wr;
                    next_addr = i_addr;
                    next_dq = i_data;
                    next_ce_n = 1'b0;
                    next_dq_oe_n = !i_wr;  // Drive only for writes.
                    next_cnt = 4'(fbc_pkg::N_SETUP - 1);
                end
            end
            CY_SETUP: begin
                if (cnt == '0) begin
                    // Write: gate stays high, strobe low; read the reverse.
                    next_st = CY_STROBE;
                    next_we_n = !wr;
                    next_oe_n = wr;
                    // Reads wait the access time, two synchroniser stages
                    // and one spare cycle, so the sample never races the
                    // moment the part's data first becomes valid.
                    next_cnt = wr ? 4'(fbc_pkg::N_STROBE - 1)
                                  : 4'(fbc_pkg::N_ACCESS + 2);
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            CY_STROBE: begin
                // Strobe length far exceeds the glitch filter width.
                if (cnt == '0) begin
                    next_st = CY_HOLD;
                    next_we_n = 1'b1;  // Data latched on this rise.
                    next_oe_n = 1'b1;
                    next_rdata = i_dq_sync;
                    next_cnt = 4'(fbc_pkg::N_HOLD - 1);
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            CY_HOLD: begin
                if (cnt == '0) begin
                    next_st = CY_IDLE;
                    next_ce_n = 1'b1;
                    next_dq_oe_n = 1'b1;
                    next_done = 1'b1;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
        endcase
    end

    // Register stage.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st <= CY_IDLE;
            cnt <= '0;
            wr <= 1'b0;
            o_rdata <= '0;
            o_done <= 1'b0;
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_addr <= '0;
            o_dq <= '0;
            o_dq_oe_n <= 1'b1;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            wr <= next_wr;
            o_rdata <= next_rdata;
            o_done <= next_done;
            o_ce_n <= next_ce_n;
            o_oe_n <= next_oe_n;
            o_we_n <= next_we_n;
            o_addr <= next_addr;
            o_dq <= next_dq;
            o_dq_oe_n <= next_dq_oe_n;
        end
    end
endmodule : fbc_cycle
`default_nettype wire

// *** rtl/fbc_host.sv ***
// Host controller that issues flash operations as pin level bus cycles.
`timescale 1ns/1ps
`default_nettype none
module fbc_host (
    // Clock and reset.
    input  wire logic                        I_CLK_SYS,
    input  wire logic                        I_SRST,
    // Operation request from user logic.
    input  wire logic                        I_REQ,
    input  wire fbc_pkg::fbc_op_t            I_OP,
    input  wire logic [fbc_pkg::ADDR_W-1:0]  I_ADDR,
    input  wire logic [fbc_pkg::DATA_W-1:0]  I_WDATA,
    output logic                             O_BUSY,
    output logic                             O_DONE,
    output logic [fbc_pkg::DATA_W-1:0]       O_RDATA,
    // Flash pins.
    output logic                             O_CE_N,
    output logic                             O_OE_N,
    output logic                             O_WE_N,
    output logic [fbc_pkg::ADDR_W-1:0]       O_A,
    output logic [fbc_pkg::DATA_W-1:0]       O_DQ,
    output logic                             O_DQ_OE_N,
    input  wire logic [fbc_pkg::DATA_W-1:0]  I_DQ
);
    typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_WAIT} fbc_hs_t;

    // Command step table: returns address/data of step k of an operation.
    function automatic logic [fbc_pkg::ADDR_W+fbc_pkg::DATA_W-1:0] step_of(
        input fbc_pkg::fbc_op_t           op,
        input logic [2:0]                 k,
        input logic [fbc_pkg::ADDR_W-1:0] a,
        input logic [fbc_pkg::DATA_W-1:0] d
    );
        logic [fbc_pkg::ADDR_W-1:0] sa;
        logic [fbc_pkg::DATA_W-1:0] cmd;
        sa = {a[fbc_pkg::ADDR_W-1:fbc_pkg::SECT_LSB],
              16'h0000};
        cmd = fbc_pkg::CMD_RESET;
        // Unlock pair opens every program, erase and identify sequence.
        if (k == 3'd3 && op == fbc_pkg::OP_PROG) begin
            // Program has a single unlock pair; step three is the byte.
            step_of = {a, d};
        end else if (k == 3'd0 || k == 3'd3) begin
            step_of = {fbc_pkg::UNLOCK_A1, fbc_pkg::UNLOCK_D1};
        end else if (k == 3'd1 || k == 3'd4) begin
            step_of = {fbc_pkg::UNLOCK_A2, fbc_pkg::UNLOCK_D2};
        end else if (k == 3'd2) begin
            unique case (op)
                fbc_pkg::OP_PROG:    cmd = fbc_pkg::CMD_PROG;
                fbc_pkg::OP_ID_READ: cmd = fbc_pkg::CMD_ID;
                default:             cmd = fbc_pkg::CMD_ERASE;
            endcase
            step_of = {fbc_pkg::UNLOCK_A1, cmd};
        end else begin
            // Final step carries the target: byte, sector or chip.
            unique case (op)
                fbc_pkg::OP_SECT_ERASE: step_of = {sa, fbc_pkg::CMD_SECT};
                fbc_pkg::OP_CHIP_ERASE:
                    step_of = {fbc_pkg::UNLOCK_A1, fbc_pkg::CMD_CHIP};
                default: step_of = {a, d};
            endcase
        end
    endfunction : step_of

    // Number of write cycles before the final (read or write) cycle.
    function automatic logic [2:0] last_of(input fbc_pkg::fbc_op_t op);
        unique case (op)
            fbc_pkg::OP_PROG:       last_of = 3'd3;
            fbc_pkg::OP_SECT_ERASE,
            fbc_pkg::OP_CHIP_ERASE: last_of = 3'd5;
            fbc_pkg::OP_ID_READ:    last_of = 3'd3;
            default:                last_of = 3'd0;
        endcase
    endfunction : last_of

    fbc_hs_t                       st, next_st;
    fbc_pkg::fbc_op_t              op, next_op;
    logic [2:0]                    k, next_k;
    logic [fbc_pkg::ADDR_W-1:0]    addr, next_addr;
    logic [fbc_pkg::DATA_W-1:0]    wdata, next_wdata;
    logic [fbc_pkg::DATA_W-1:0]    next_rdata;
    logic                          next_busy, next_done;
    logic                          go, next_go;
    logic                          cy_wr, next_cy_wr;
    logic [fbc_pkg::ADDR_W-1:0]    cy_addr, next_cy_addr;
    logic [fbc_pkg::DATA_W-1:0]    cy_data, next_cy_data;
    logic                          cy_done;
    logic [fbc_pkg::DATA_W-1:0]    cy_rdata;
    // Two-stage synchroniser for the asynchronous data pins.
    logic [fbc_pkg::DATA_W-1:0]    dq_meta, dq_sync;

    always_ff @(posedge I_CLK_SYS) begin
        dq_meta <= I_DQ;
        dq_sync <= dq_meta;
    end

    // Operation sequencer: walks command steps, then the final cycle.
    always_comb begin
        logic [fbc_pkg::ADDR_W+fbc_pkg::DATA_W-1:0] s;
        s = step_of(op, k, addr, wdata);
        next_st = st;
        next_op = op;
        next_k = k;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = O_RDATA;
        next_busy = O_BUSY;
        next_done = 1'b0;
        next_go = 1'b0;
        next_cy_wr = cy_wr;
        next_cy_addr = cy_addr;
        next_cy_data = cy_data;
        unique case (st)
            HS_IDLE: begin
                // Requests are taken only while idle.
                if (I_REQ) begin
                    next_st = HS_ISSUE;
                    next_op = I_OP;
                    next_addr = I_ADDR;
                    next_wdata = I_WDATA;
                    next_k = '0;
                    next_busy = 1'b1;
                end
            end
            HS_ISSUE: begin
                next_go = 1'b1;
                next_st = HS_WAIT;
                if (op == fbc_pkg::OP_READ) begin
                    // Plain read needs no command: part rests in read mode.
                    next_cy_wr = 1'b0;
                    next_cy_addr = addr;
                end else if (op == fbc_pkg::OP_WRITE) begin
                    // Raw write of the user's data at the user's address.
                    next_cy_wr = 1'b1;
                    next_cy_addr = addr;
                    next_cy_data = wdata;
                end else if (op == fbc_pkg::OP_RESET) begin
                    next_cy_wr = 1'b1;
                    next_cy_addr = addr;
                    next_cy_data = fbc_pkg::CMD_RESET;
                end else if (op == fbc_pkg::OP_ID_READ &&
                             k == last_of(op)) begin
                    // Identify read at the user's low offset.
                    next_cy_wr = 1'b0;
                    next_cy_addr = addr;
                end else begin
                    next_cy_wr = 1'b1;
                    next_cy_addr = s[fbc_pkg::ADDR_W+fbc_pkg::DATA_W-1:
                                     fbc_pkg::DATA_W];
                    next_cy_data = s[fbc_pkg::DATA_W-1:0];
                end
            end
            HS_WAIT: begin
                if (cy_done) begin
                    if (k == last_of(op) || op == fbc_pkg::OP_READ ||
                        op == fbc_pkg::OP_WRITE || op == fbc_pkg::OP_RESET)
                    begin
                        // Program/erase then run on; status read by polling.
                        next_st = HS_IDLE;
                        next_rdata = cy_rdata;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                    end else begin
                        next_k = k + 3'd1;
                        next_st = HS_ISSUE;
                    end
                end
            end
            default: next_st = HS_IDLE;
        endcase
    end

    // Register stage of the sequencer.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            st <= HS_IDLE;
            op <= fbc_pkg::OP_READ;
            k <= '0;
            addr <= '0;
            wdata <= '0;
            O_RDATA <= '0;
            O_BUSY <= 1'b0;
            O_DONE <= 1'b0;
            go <= 1'b0;
            cy_wr <= 1'b0;
            cy_addr <= '0;
            cy_data <= '0;
        end else begin
            st <= next_st;
            op <= next_op;
            k <= next_k;
            addr <= next_addr;
            wdata <= next_wdata;
            O_RDATA <= next_rdata;
            O_BUSY <= next_busy;
            O_DONE <= next_done;
            go <= next_go;
            cy_wr <= next_cy_wr;
            cy_addr <= next_cy_addr;
            cy_data <= next_cy_data;
        end
    end

    // Pin cycle engine; its outputs are flip-flops.
    fbc_cycle u_cycle (
        .i_clk     (I_CLK_SYS),
        .i_srst    (I_SRST),
        .i_go      (go),
        .i_wr      (cy_wr),
        .i_addr    (cy_addr),
        .i_data    (cy_data),
        .o_done    (cy_done),
        .o_rdata   (cy_rdata),
        .o_ce_n    (O_CE_N),
        .o_oe_n    (O_OE_N),
        .o_we_n    (O_WE_N),
        .o_addr    (O_A),
        .o_dq      (O_DQ),
        .o_dq_oe_n (O_DQ_OE_N),
        .i_dq_sync (dq_sync)
    );
endmodule : fbc_host
`default_nettype wire

// *** rtl/fbc_pkg.sv ***
// Package of constants and types for the flash bus host controller.
package fbc_pkg;
    // Bus widths of the external flash part.
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // Sector select field position within the address.
    localparam int SECT_LSB = 16;
    localparam int SECT_W   = 3;
    // Bus phase timing in ns, printed figures.
    localparam int T_SETUP_NS  = 30;  // Address setup before strobe low.
    localparam int T_STROBE_NS = 40;  // Strobe low width, well above glitch.
    localparam int T_ACCESS_NS = 70;  // Read access time.
    localparam int T_HOLD_NS   = 20;  // Hold after strobe release.
    localparam int CLK_NS      = 10;
    // Derived cycle counts: least times round up.
    localparam int N_SETUP  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int N_STROBE = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int N_ACCESS = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int N_HOLD   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W    = 4;
    // Command sequence constants.
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 19'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 19'h002aa;
    localparam logic [DATA_W-1:0] UNLOCK_D1 = 8'haa;
    localparam logic [DATA_W-1:0] UNLOCK_D2 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_RESET = 8'hf0;
    localparam logic [DATA_W-1:0] CMD_ID    = 8'h90;
    localparam logic [DATA_W-1:0] CMD_PROG  = 8'ha0;
    localparam logic [DATA_W-1:0] CMD_ERASE = 8'h80;
    localparam logic [DATA_W-1:0] CMD_CHIP  = 8'h10;
    localparam logic [DATA_W-1:0] CMD_SECT  = 8'h30;
    // Identification read offsets.
    localparam logic [7:0] ID_MAKER = 8'h00;
    localparam logic [7:0] ID_PART  = 8'h01;
    localparam logic [7:0] ID_PROT  = 8'h02;
    localparam logic [7:0] ID_CONT  = 8'h03;
    // Host operation codes.
    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_PROG, OP_SECT_ERASE, OP_CHIP_ERASE,
        OP_ID_READ, OP_RESET
    } fbc_op_t;
endpackage : fbc_pkg
